// >>> plps_pkg.sv
package plps_pkg;
    localparam int NUM_IN = 12;
    localparam int NUM_MC = 10;
    localparam int SIG_BITS = 64;
    localparam int SIG_BYTES = 8;
    localparam int MAP_BITS_BASIC = 5828;
    localparam int MAP_BITS_SIG = 5892;
    localparam int MAP_BITS_PD = 5893;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SIG_LO = 8'h08;
    localparam logic [7:0] REG_SIG_HI = 8'h0c;
    localparam logic [7:0] REG_PRELOAD = 8'h10;
    localparam logic [7:0] REG_MODE = 8'h14;
    localparam logic [7:0] REG_TERM = 8'h18;

    // Control register fields
    localparam int CTRL_PD_EN_BIT = 0;
    localparam int CTRL_LOCK_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status register fields
    localparam int STAT_SLEEP_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;

    // Preload register fields: value in 9:0, strobe at bit 16
    localparam int PRELOAD_GO_BIT = 16;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Macrocell output modes: bit0 registered, bit1 active low
    typedef enum logic [1:0] {
        PLPS_COMB_HIGH = 2'b00,
        PLPS_REG_HIGH = 2'b01,
        PLPS_COMB_LOW = 2'b10,
        PLPS_REG_LOW = 2'b11
    } plps_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } plps_wreq_t;

    typedef struct packed {
        logic [NUM_MC-1:0] oe;
        logic [NUM_MC-1:0] val;
    } plps_pins_t;
endpackage

// >>> plps_keeper.sv
`timescale 1ns/1ps
`default_nettype none
// Weak hold of each pin: a driven pin updates the held level, an idle one keeps it
module plps_keeper
    import plps_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hold,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_driven,
    output logic [WIDTH-1:0] level_r
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_keep
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    level_r[i] <= 1'b0;
                end else if (!hold && pin_driven[i]) begin
                    level_r[i] <= pin_in[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> plps_macrocell.sv
`timescale 1ns/1ps
`default_nettype none
// One output macrocell: product-term sum, register, polarity and path select
module plps_macrocell
    import plps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hold,
    input wire logic sum_in,
    input wire plps_pkg::plps_mode_t mode,
    input wire logic preload_go,
    input wire logic preload_val,
    output logic feedback_r,
    output logic pin_r
);
    logic pin_nxt;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            feedback_r <= 1'b0;
        end else if (preload_go) begin
            feedback_r <= preload_val;
        end else if (!hold) begin
            feedback_r <= sum_in;
        end
    end

    always_comb begin
        pin_nxt = mode[0] ? feedback_r : sum_in;
        if (mode[1]) begin
            pin_nxt = ~pin_nxt;
        end
    end

    // Combinational path is also registered so the pin comes from a flop
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_r <= 1'b0;
        end else if (!hold) begin
            pin_r <= pin_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> plps_core.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 64-bit user signature stays readable and writable whether or not locked.
// - With the lock set, fuse readback and register preload are refused.
// - Undriven input and I/O pins keep their last driven level.
// - Power-down enabled and power-down pin high enters standby.
// - In standby all outputs are held, and macrocell registers too except that an unlocked preload still loads them.
// - An output undetermined at standby entry stays so throughout.
// - In standby all inputs except the power-down pin are ignored.
// - Pin hold latches stay active during standby.
// - With power-down enabled the shared pin does not feed the array.
// - Without power-down the shared pin is an ordinary array input.
// - Power-down enable is a separate configuration bit; map sizes 5828/5892/5893.
// - Twelve dedicated inputs and ten I/O macrocells feed the array.
// - Each macrocell: active high or low, registered or combinational.
// - Signature organised as eight user-writable bytes.
// - Unless locked, each macrocell register can be preloaded high or low.
// - At reset all macrocell registers clear low.
module plps_core
    import plps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [NUM_IN-1:0] in_pin,
    input wire logic [NUM_IN-1:0] in_driven,
    input wire logic shared_input_sleep_pin,
    input wire logic [NUM_MC-1:0] io_in,
    input wire logic [NUM_MC-1:0] io_driven,
    output plps_pkg::plps_pins_t io_out_r,
    output logic sleeping_r,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0] {
        PLPS_W_IDLE = 3'b001,
        PLPS_W_RESP = 3'b010,
        PLPS_W_GOT = 3'b100
    } plps_wstate_t;

    logic pd_en_r;
    logic lock_r;
    logic refused_r;
    logic [SIG_BITS-1:0] sig_r;
    logic [2*NUM_MC-1:0] mode_r;
    logic [NUM_MC-1:0] term_r;
    logic preload_go_r;
    logic [NUM_MC-1:0] preload_val_r;
    logic [NUM_IN-1:0] in_level;
    logic [NUM_MC-1:0] io_level;
    logic [NUM_MC-1:0] feedback;
    logic [NUM_MC-1:0] pin_val;
    logic [NUM_MC-1:0] sum;
    logic sleep_now;
    logic [NUM_IN-1:0] in_gated;

    plps_wstate_t wstate_r;
    logic aw_have_r;
    logic w_have_r;
    plps_wreq_t wreq_r;
    logic wr_fire;
    logic wr_err;

    // Only the shared pin is looked at in standby; all other pins are held
    assign sleep_now = pd_en_r && shared_input_sleep_pin;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sleeping_r <= 1'b0;
        end else begin
            sleeping_r <= sleep_now;
        end
    end

    // Input 3 is the shared pin; keepers freeze every input in standby
    plps_keeper #(.WIDTH(NUM_IN)) u_in_keep (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .hold(sleep_now),
        .pin_in(in_pin),
        .pin_driven(in_driven),
        .level_r(in_level)
    );

    plps_keeper #(.WIDTH(NUM_MC)) u_io_keep (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .hold(sleep_now),
        .pin_in(io_in),
        .pin_driven(io_driven),
        .level_r(io_level)
    );

    // Input 3 reads low with power-down on; its macrocell and feedback keep working
    always_comb begin
        in_gated = in_level;
        in_gated[3] = pd_en_r ? 1'b0 : in_level[3];
    end

    // Stand-in for the product-term array: XOR of a selected input term
    // with macrocell feedback and pin level, enough to exercise each path
    genvar m;
    generate
        for (m = 0; m < NUM_MC; m = m + 1) begin : g_mc
            assign sum[m] = (term_r[m] ? in_gated[m] : in_gated[m + 2]) ^ feedback[(m + 1) % NUM_MC]
                ^ io_level[m];
            plps_macrocell u_mc (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .hold(sleep_now),
                .sum_in(sum[m]),
                .mode(plps_mode_t'(mode_r[2*m +: 2])),
                .preload_go(preload_go_r),
                .preload_val(preload_val_r[m]),
                .feedback_r(feedback[m]),
                .pin_r(pin_val[m])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            io_out_r <= '0;
        end else if (!sleep_now) begin
            io_out_r.val <= pin_val;
            io_out_r.oe <= {NUM_MC{1'b1}};
        end
    end

    // Write channel: address and data taken in either order
    assign wr_fire = aw_have_r && w_have_r && (wstate_r == PLPS_W_IDLE);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            wreq_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && (wstate_r == PLPS_W_IDLE);
            s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && (wstate_r == PLPS_W_IDLE);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                wreq_r.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wreq_r.data <= s_axi_wdata;
                wreq_r.strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_err = 1'b0;
        if (wreq_r.addr == REG_CTRL) begin
            wr_err = 1'b0;
        end else if (wreq_r.addr == REG_SIG_LO || wreq_r.addr == REG_SIG_HI) begin
            wr_err = 1'b0;
        end else if (wreq_r.addr == REG_PRELOAD) begin
            wr_err = lock_r;
        end else if (wreq_r.addr == REG_MODE || wreq_r.addr == REG_TERM) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wstate_r <= PLPS_W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wstate_r)
                PLPS_W_IDLE: begin
                    if (wr_fire) begin
                        wstate_r <= PLPS_W_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
                    end
                end
                PLPS_W_RESP: begin
                    if (s_axi_bready) begin
                        wstate_r <= PLPS_W_GOT;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wstate_r <= PLPS_W_IDLE;
                end
            endcase
        end
    end

    // Register effects of an accepted write
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pd_en_r <= CTRL_RESET[CTRL_PD_EN_BIT];
            lock_r <= CTRL_RESET[CTRL_LOCK_BIT];
            mode_r <= '0;
            term_r <= '0;
        end else if (wr_fire && wreq_r.strb[0]) begin
            if (wreq_r.addr == REG_CTRL) begin
                pd_en_r <= wreq_r.data[CTRL_PD_EN_BIT];
                // Lock is one-way until reset and acts on the next access
                lock_r <= lock_r | wreq_r.data[CTRL_LOCK_BIT];
            end else if (wreq_r.addr == REG_TERM) begin
                term_r <= wreq_r.data[NUM_MC-1:0];
            end
        end
        if (resetn && wr_fire && wreq_r.addr == REG_MODE) begin
            if (wreq_r.strb[0]) begin
                mode_r[7:0] <= wreq_r.data[7:0];
            end
            if (wreq_r.strb[1]) begin
                mode_r[15:8] <= wreq_r.data[15:8];
            end
            if (wreq_r.strb[2]) begin
                mode_r[19:16] <= wreq_r.data[19:16];
            end
        end
    end

    // Signature bytes are byte-writable, independent of the lock
    genvar b;
    generate
        for (b = 0; b < SIG_BYTES; b = b + 1) begin : g_sig
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    sig_r[8*b +: 8] <= 8'h00;
                end else if (wr_fire && wreq_r.strb[b % 4]
                             && wreq_r.addr == ((b < 4) ? REG_SIG_LO : REG_SIG_HI)) begin
                    sig_r[8*b +: 8] <= wreq_r.data[8*(b % 4) +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            preload_go_r <= 1'b0;
            preload_val_r <= '0;
        end else begin
            preload_go_r <= 1'b0;
            if (wr_fire && wreq_r.addr == REG_PRELOAD && !lock_r && wreq_r.data[PRELOAD_GO_BIT]) begin
                preload_go_r <= 1'b1;
                preload_val_r <= wreq_r.data[NUM_MC-1:0];
            end
        end
    end

    // Sticky flag for refused preload or mode/term readback (a refused preload readback does not set it); reading status clears it, set wins
    logic refuse_evt;
    logic rd_fire;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign refuse_evt = (wr_fire && wreq_r.addr == REG_PRELOAD && lock_r)
        || (rd_fire && lock_r && (s_axi_araddr == REG_MODE || s_axi_araddr == REG_TERM));

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            refused_r <= 1'b0;
        end else if (refuse_evt) begin
            refused_r <= 1'b1;
        end else if (rd_fire && s_axi_araddr == REG_STATUS) begin
            refused_r <= 1'b0;
        end
    end

    // Read channel: one read in flight, answer one cycle after the address is taken
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                if (s_axi_araddr == REG_CTRL) begin
                    s_axi_rdata[CTRL_PD_EN_BIT] <= pd_en_r;
                    s_axi_rdata[CTRL_LOCK_BIT] <= lock_r;
                end else if (s_axi_araddr == REG_STATUS) begin
                    s_axi_rdata[STAT_SLEEP_BIT] <= sleeping_r;
                    s_axi_rdata[STAT_LOCK_BIT] <= lock_r;
                    s_axi_rdata[STAT_REFUSED_BIT] <= refused_r;
                end else if (s_axi_araddr == REG_SIG_LO) begin
                    s_axi_rdata <= sig_r[31:0];
                end else if (s_axi_araddr == REG_SIG_HI) begin
                    s_axi_rdata <= sig_r[63:32];
                end else if (s_axi_araddr == REG_MODE || s_axi_araddr == REG_TERM) begin
                    if (lock_r) begin
                        s_axi_rresp <= RESP_SLVERR;
                    end else if (s_axi_araddr == REG_MODE) begin
                        s_axi_rdata[2*NUM_MC-1:0] <= mode_r;
                    end else begin
                        s_axi_rdata[NUM_MC-1:0] <= term_r;
                    end
                end else if (s_axi_araddr == REG_PRELOAD) begin
                    s_axi_rdata[NUM_MC-1:0] <= feedback;
                    if (lock_r) begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> plps_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module plps_core_monitor
    import plps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic shared_input_sleep_pin,
    input wire plps_pkg::plps_pins_t io_out_r,
    input wire logic sleeping_r,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    a_sleep_entry: assert property ($rose(sleeping_r) |-> $past(shared_input_sleep_pin))
        else $error("standby entered without sleep pin");
    a_sleep_exit: assert property (!shared_input_sleep_pin |=> !sleeping_r)
        else $error("standby kept after sleep pin fell");
    a_sleep_stay: assert property (sleeping_r && shared_input_sleep_pin |=> sleeping_r)
        else $error("standby left while sleep pin high");
    // A control write can clear power-down enable and end the hold, so only idle write channels qualify
    a_hold_outputs: assert property (sleeping_r && shared_input_sleep_pin && s_axi_wready
        ##1 shared_input_sleep_pin |-> $stable(io_out_r)) else $error("pin outputs moved in standby");
    a_reset_clear: assert property ($rose(resetn) |-> io_out_r.val == '0 && !sleeping_r)
        else $error("outputs not clear after reset");
    // Both halves are taken one edge, the pair is acted on the next, the response shows after that
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    c_sleep: cover property ($rose(sleeping_r));
    c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind plps_core plps_core_monitor plps_core_monitor_inst (
    .clk_sys, .resetn, .shared_input_sleep_pin, .io_out_r, .sleeping_r, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rresp, .s_axi_rvalid
);
`default_nettype wire

// >>> plps_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module plps_pin_model
    import plps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [NUM_IN-1:0] in_val,
    input wire logic [NUM_IN-1:0] in_drv,
    input wire logic [NUM_MC-1:0] io_val,
    input wire logic [NUM_MC-1:0] io_drv,
    input wire plps_pkg::plps_pins_t pins,
    output logic [NUM_IN-1:0] in_pin,
    output logic [NUM_IN-1:0] in_driven,
    output logic [NUM_MC-1:0] io_in,
    output logic [NUM_MC-1:0] io_driven
);
    logic [NUM_IN-1:0] in_last_r = '0;
    logic [NUM_MC-1:0] io_last_r = '0;
    logic [NUM_MC-1:0] io_ext;
    // A released line shows the inverse of its last level, so only the keeper can hold it
    assign in_pin = (in_drv & in_val) | (~in_drv & ~in_last_r);
    assign in_driven = in_drv;
    assign io_ext = io_drv & ~pins.oe;
    assign io_in = (pins.oe & pins.val) | (io_ext & io_val) | (~pins.oe & ~io_ext & ~io_last_r);
    assign io_driven = io_ext | pins.oe;
    // Remember only driven levels, so a released line keeps showing their inverse
    always @(posedge clk_sys) begin
        in_last_r <= (in_drv & in_pin) | (~in_drv & in_last_r);
        io_last_r <= (io_driven & io_in) | (~io_driven & io_last_r);
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import plps_pkg::*;
    logic clk_sys, sleeping_r, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic resetn = 1'b0, shared_input_sleep_pin = 1'b0;
    logic [NUM_IN-1:0] in_val = '0, in_drv = '1, in_pin, in_driven;
    logic [NUM_MC-1:0] io_val = '0, io_drv = '0, io_in, io_driven;
    plps_pins_t io_out_r;
    plps_pins_t held_pins;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] rst_regs[6] = '{REG_CTRL, REG_STATUS, REG_SIG_LO, REG_SIG_HI, REG_PRELOAD, REG_MODE};
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    plps_core plps_core_inst (
        .clk_sys, .resetn, .in_pin, .in_driven, .shared_input_sleep_pin, .io_in, .io_driven, .io_out_r,
        .sleeping_r, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    plps_pin_model plps_pin_model_inst (
        .clk_sys, .in_val, .in_drv, .io_val, .io_drv, .pins(io_out_r), .in_pin, .in_driven, .io_in, .io_driven
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under 1000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("unexpected cycle count: expected below 3000, seen %0d", cycles);
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_bvalid) break;
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        chk($sformatf("bresp at %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_done;
        ar_done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (ar_done && s_axi_rvalid) break;
            if (!ar_done && s_axi_arready) begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        chk($sformatf("rresp at %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
        chk($sformatf("rdata at %h", a), ed, s_axi_rdata);
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        foreach (rst_regs[i]) rd(rst_regs[i], 32'h0, RESP_OKAY);
        chk("io_out_r.oe", 32'h3ff, {22'h0, io_out_r.oe});
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h1, 4'hf, RESP_SLVERR);
        wr(REG_SIG_LO, 32'h11223344, 4'hf, RESP_OKAY);
        wr(REG_SIG_HI, 32'h55667788, 4'hf, RESP_OKAY);
        wr(REG_SIG_LO, 32'haabbccdd, 4'h2, RESP_OKAY);
        rd(REG_SIG_LO, 32'h1122cc44, RESP_OKAY);
        rd(REG_SIG_HI, 32'h55667788, RESP_OKAY);
        wr(REG_MODE, {16'h0, {2{PLPS_REG_LOW, PLPS_COMB_LOW, PLPS_REG_HIGH, PLPS_COMB_HIGH}}}, 4'hf, RESP_OKAY);
        rd(REG_MODE, 32'h0000e4e4, RESP_OKAY);
        // Pin high with the option off must not sleep
        shared_input_sleep_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("sleeping_r", 32'h0, {31'h0, sleeping_r});
        wr(REG_CTRL, 32'h1, 4'h1, RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk("sleeping_r", 32'h1, {31'h0, sleeping_r});
        held_pins = io_out_r;
        rd(REG_STATUS, 32'h1, RESP_OKAY);
        wr(REG_PRELOAD, 32'h000102a5, 4'hf, RESP_OKAY);
        in_val <= '1;
        in_drv <= 12'h0f0;
        io_drv <= '1;
        io_val <= '1;
        repeat (8) @(posedge clk_sys);
        chk("io_out_r", {12'h0, held_pins}, {12'h0, io_out_r});
        rd(REG_PRELOAD, 32'h000002a5, RESP_OKAY);
        rd(REG_CTRL, 32'h1, RESP_OKAY);
        shared_input_sleep_pin <= 1'b0;
        in_drv <= '1;
        repeat (2) @(posedge clk_sys);
        chk("sleeping_r", 32'h0, {31'h0, sleeping_r});
        // Lock goes last: it shuts verify at once
        wr(REG_CTRL, 32'h3, 4'h1, RESP_OKAY);
        rd(REG_STATUS, 32'h2, RESP_OKAY);
        wr(REG_PRELOAD, 32'h00010000, 4'hf, RESP_SLVERR);
        rd(REG_STATUS, 32'h6, RESP_OKAY);
        rd(REG_STATUS, 32'h2, RESP_OKAY);
        rd(REG_MODE, 32'h0, RESP_SLVERR);
        rd(REG_PRELOAD, 32'h0, RESP_SLVERR);
        wr(REG_SIG_HI, 32'hcafe0001, 4'hf, RESP_OKAY);
        rd(REG_SIG_HI, 32'hcafe0001, RESP_OKAY);
        rd(REG_SIG_LO, 32'h1122cc44, RESP_OKAY);
        // Quiet inputs so the array stays at zero and the cleared registers can be seen
        in_val <= '0;
        io_drv <= '0;
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd(REG_CTRL, 32'h0, RESP_OKAY);
        rd(REG_PRELOAD, 32'h0, RESP_OKAY);
        chk("io_out_r.val", 32'h0, {22'h0, io_out_r.val});
        stop_test();
    end
endmodule
`default_nettype wire
